// ---- cifd_pkg.sv ----
// Constants, field layouts and enumerations shared by the instruction decoder.
// Assumes one sys_clk period stands for one oscillator period.
package cifd_pkg;

  // Instruction word widths
  localparam int unsigned CIFD_WORD_W = 16;
  localparam int unsigned CIFD_EXT_W = 12;

  // Phases per instruction cycle and the phase numbers
  localparam logic [1:0] CIFD_PH_DECODE = 2'h0;
  localparam logic [1:0] CIFD_PH_READ = 2'h1;
  localparam logic [1:0] CIFD_PH_PROCESS = 2'h2;
  localparam logic [1:0] CIFD_PH_WRITE = 2'h3;
  localparam int unsigned CIFD_PHASES = 4;

  // Clock figures: an instruction cycle is four clock periods
  localparam int unsigned CIFD_CLK_PERIOD_NS = 50;
  localparam int unsigned CIFD_ICYC_NS = CIFD_PHASES * CIFD_CLK_PERIOD_NS;
  localparam int unsigned CIFD_ICYC_CLKS = CIFD_ICYC_NS / CIFD_CLK_PERIOD_NS;

  // Upper nibble of every second word, and the load literal upper byte
  localparam logic [3:0] CIFD_SECOND_TAG = 4'hf;
  localparam logic [7:0] CIFD_LOAD_LIT_OP = 8'h0e;

  // Field positions inside a word
  localparam int unsigned CIFD_DEST_BIT = 9;
  localparam int unsigned CIFD_ACCESS_BIT = 8;
  localparam int unsigned CIFD_BITNUM_LSB = 9;
  localparam int unsigned CIFD_PTR_LSB = 4;
  localparam int unsigned CIFD_CALL_S_BIT = 8;

  // Reset values
  localparam logic [7:0] CIFD_WORKING_RST = 8'h00;
  localparam logic [15:0] CIFD_WORD_RST = 16'h0000;

  // Instruction classes
  typedef enum logic [2:0] {
    CLS_NOP = 3'b000,
    CLS_BYTE = 3'b001,
    CLS_BIT = 3'b010,
    CLS_LITERAL = 3'b011,
    CLS_CONTROL = 3'b100,
    CLS_LOAD_LIT = 3'b101,
    CLS_EXT = 3'b110
  } cifd_class_e;

  // Treatment of the current instruction cycle
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_SECOND = 2'b01,
    ST_FLUSH = 2'b10
  } cifd_state_e;

  // True for a word that can only be the second half of a long instruction
  function automatic logic cifd_is_second(input logic [15:0] w);
    return w[15:12] == CIFD_SECOND_TAG;
  endfunction

  // True for the load literal to working register opcode
  function automatic logic cifd_is_load_lit(input logic [15:0] w);
    return w[15:8] == CIFD_LOAD_LIT_OP;
  endfunction

endpackage

// ---- cifd_phase_gen.sv ----
// Four-phase generator that splits each instruction cycle into clock periods.
// Assumes sys_clk is the oscillator and reset_n is asynchronous, active low.
`timescale 1ns/100ps
module cifd_phase_gen
  import cifd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic [1:0] phase_q
);

  logic [1:0] phase_d; // Next phase

  // Advance one phase per oscillator period, wrapping after the fourth
  always_comb begin
    phase_d = phase_q + 2'h1;
  end

  // Phase register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= CIFD_PH_DECODE;
    end else begin
      phase_q <= phase_d;
    end
  end

  a_phase_wrap: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_WRITE) |=> (phase_q == CIFD_PH_DECODE))
    else $error("phase did not wrap after the fourth period");

  a_phase_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_DECODE) |=> ##2 (phase_q == CIFD_PH_WRITE))
    else $error("instruction cycle is not four periods long");

endmodule

// ---- cifd_field_split.sv ----
// Combinational split of one instruction word into its class and operand fields.
// Assumes the caller registers the outputs; no state is held here.
`timescale 1ns/100ps
module cifd_field_split
  import cifd_pkg::*;
(
  input wire logic [15:0] word,
  output cifd_class_e cls,
  output logic is_double,
  output logic pc_change,
  output logic conditional,
  output logic [7:0] file_addr,
  output logic dest_file,
  output logic access_sel,
  output logic [2:0] bit_num,
  output logic [7:0] literal,
  output logic [1:0] pointer_sel,
  output logic [10:0] branch_off,
  output logic call_mode,
  output logic [1:0] table_mode
);

  // Operand fields other than call_mode and branch_off sit at fixed places, so they are cut for every word
  always_comb begin
    file_addr = word[7:0];
    dest_file = word[CIFD_DEST_BIT];
    access_sel = word[CIFD_ACCESS_BIT];
    bit_num = word[CIFD_BITNUM_LSB +: 3];
    literal = word[7:0];
    pointer_sel = word[CIFD_PTR_LSB +: 2];
    branch_off = word[10:0];
    table_mode = word[1:0];
    call_mode = word[CIFD_CALL_S_BIT];
    cls = CLS_NOP;
    is_double = 1'b0;
    pc_change = 1'b0;
    conditional = 1'b0;
    // Opcode portion in the upper bits names the instruction type
    case (word[15:12])
      4'h0: begin
        if (cifd_is_load_lit(word)) begin
          cls = CLS_LOAD_LIT;
        end else if (word[15:8] == 8'h00) begin
          // Table access, return or no operand
          cls = CLS_CONTROL;
          pc_change = (word[7:1] == 7'h09);
          call_mode = word[0];
          if (word[7:0] == 8'h00) begin
            cls = CLS_NOP;
          end
        end else begin
          cls = CLS_LITERAL;
        end
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
        cls = CLS_BYTE;
      end
      4'h6, 4'h7, 4'h8, 4'h9: begin
        cls = CLS_BIT;
      end
      4'ha, 4'hb: begin
        // Bit test that skips the next word when true
        cls = CLS_BIT;
        conditional = 1'b1;
      end
      4'hc: begin
        // Long file-to-file move
        cls = CLS_BYTE;
        is_double = 1'b1;
      end
      4'hd: begin
        cls = CLS_CONTROL;
        pc_change = 1'b1;
      end
      4'he: begin
        cls = CLS_CONTROL;
        if (word[11] == 1'b0) begin
          // Short conditional branch
          branch_off = {3'h0, word[7:0]};
          conditional = 1'b1;
        end else if (word[11:9] == 3'h6) begin
          is_double = 1'b1;
        end else if (word[11:8] == 4'he) begin
          cls = CLS_LITERAL;
          is_double = 1'b1;
        end else if (word[11:8] == 4'hf) begin
          is_double = 1'b1;
        end else begin
          cls = CLS_LITERAL;
        end
      end
      default: begin
        // Orphaned second word runs as a no-op
        cls = CLS_NOP;
      end
    endcase
  end

endmodule

// ---- cifd_decoder.sv ----
// Instruction format decoder and cycle timing for an 8-bit core.
// Assumes the fetch path holds fetch_word stable through the decode phase
// and that cond_true and alu_result come from logic on sys_clk.
//
// Functional notes
// - Single instructions are one 16-bit word
// - Four instructions span two words, 32 bits
// - Lone second word, top nibble ones, is no-op
// - Destination bit zero working, one file
// - Byte ops give file, destination, access bits
// - Bit ops give file, bit number, access
// - Literal ops give literal, pointer select, or none
// - Control ops give address, mode fields, or none
// - One cycle; two when taken or jumping
// - Double-word instructions take two cycles
// - Instruction cycle is four oscillator periods
// - Taken skip over two-word instruction: three cycles
// - Load literal copies low byte, flags untouched
`timescale 1ns/100ps
module cifd_decoder
  import cifd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [15:0] fetch_word,
  input wire logic cond_true,
  input wire logic [7:0] alu_result,
  output logic [1:0] phase_q,
  output logic fetch_take_q,
  output logic [2:0] instr_class_q,
  output logic is_nop_q,
  output logic second_word_q,
  output logic [7:0] file_addr_q,
  output logic dest_file_q,
  output logic access_sel_q,
  output logic [2:0] bit_num_q,
  output logic [7:0] literal_q,
  output logic [1:0] pointer_sel_q,
  output logic [10:0] branch_off_q,
  output logic call_mode_q,
  output logic [1:0] table_mode_q,
  output logic [11:0] ext_word_q,
  output logic [7:0] working_register_q,
  output logic cycle_end_q
);

  // Fields of the word now on the fetch port
  cifd_class_e f_cls;
  logic f_double;
  logic f_pc_change;
  logic f_cond;
  logic [7:0] f_file;
  logic f_dest;
  logic f_access;
  logic [2:0] f_bit;
  logic [7:0] f_lit;
  logic [1:0] f_ptr;
  logic [10:0] f_off;
  logic f_call;
  logic [1:0] f_table;

  // Decode state of the current instruction cycle
  cifd_state_e state_q;
  cifd_state_e state_d;
  cifd_class_e cls_q;
  cifd_class_e cls_d;
  logic double_q; // Latched word opens a two-word instruction
  logic double_d;
  logic pc_change_q; // Latched word always moves the program counter
  logic pc_change_d;
  logic cond_q; // Latched word has a conditional outcome
  logic cond_d;
  logic taken; // Extra cycle needed after this one

  // Registered outputs, next values
  logic fetch_take_d;
  logic is_nop_d;
  logic second_word_d;
  logic [7:0] file_addr_d;
  logic dest_file_d;
  logic access_sel_d;
  logic [2:0] bit_num_d;
  logic [7:0] literal_d;
  logic [1:0] pointer_sel_d;
  logic [10:0] branch_off_d;
  logic call_mode_d;
  logic [1:0] table_mode_d;
  logic [11:0] ext_word_d;
  logic [7:0] lit_hold_q; // Literal read in the second phase
  logic [7:0] lit_hold_d;
  logic [7:0] working_register_d;
  logic cycle_end_d;

  // Phase counter of the four-period instruction cycle
  cifd_phase_gen u_phase (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .phase_q(phase_q)
  );

  // Field extraction of the incoming word
  cifd_field_split u_split (
    .word(fetch_word),
    .cls(f_cls),
    .is_double(f_double),
    .pc_change(f_pc_change),
    .conditional(f_cond),
    .file_addr(f_file),
    .dest_file(f_dest),
    .access_sel(f_access),
    .bit_num(f_bit),
    .literal(f_lit),
    .pointer_sel(f_ptr),
    .branch_off(f_off),
    .call_mode(f_call),
    .table_mode(f_table)
  );

  // Word latch: the decode phase takes the fetched word
  always_comb begin
    fetch_take_d = (phase_q == CIFD_PH_DECODE);
    cls_d = cls_q;
    double_d = double_q;
    pc_change_d = pc_change_q;
    cond_d = cond_q;
    is_nop_d = is_nop_q;
    second_word_d = second_word_q;
    file_addr_d = file_addr_q;
    dest_file_d = dest_file_q;
    access_sel_d = access_sel_q;
    bit_num_d = bit_num_q;
    literal_d = literal_q;
    pointer_sel_d = pointer_sel_q;
    branch_off_d = branch_off_q;
    call_mode_d = call_mode_q;
    table_mode_d = table_mode_q;
    ext_word_d = ext_word_q;
    if (phase_q == CIFD_PH_DECODE) begin
      double_d = f_double;
      file_addr_d = f_file;
      dest_file_d = f_dest;
      access_sel_d = f_access;
      bit_num_d = f_bit;
      literal_d = f_lit;
      pointer_sel_d = f_ptr;
      branch_off_d = f_off;
      call_mode_d = f_call;
      table_mode_d = f_table;
      case (state_q)
        ST_SECOND: begin
          // Operand word of a two-word instruction, not executed alone
          cls_d = CLS_EXT;
          is_nop_d = 1'b0;
          second_word_d = 1'b1;
          ext_word_d = fetch_word[CIFD_EXT_W-1:0];
          pc_change_d = 1'b0;
          cond_d = 1'b0;
          double_d = 1'b0;
        end
        ST_FLUSH: begin
          // Discarded word runs as a no-op, its length is still tracked
          cls_d = CLS_NOP;
          is_nop_d = 1'b1;
          second_word_d = 1'b0;
          pc_change_d = 1'b0;
          cond_d = 1'b0;
        end
        default: begin
          cls_d = f_cls;
          is_nop_d = cifd_is_second(fetch_word) || (f_cls == CLS_NOP);
          second_word_d = 1'b0;
          pc_change_d = f_pc_change;
          cond_d = f_cond;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_take_q <= 1'b0;
      cls_q <= CLS_NOP;
      double_q <= 1'b0;
      pc_change_q <= 1'b0;
      cond_q <= 1'b0;
      is_nop_q <= 1'b1;
      second_word_q <= 1'b0;
      file_addr_q <= CIFD_WORKING_RST;
      dest_file_q <= 1'b0;
      access_sel_q <= 1'b0;
      bit_num_q <= 3'h0;
      literal_q <= CIFD_WORKING_RST;
      pointer_sel_q <= 2'h0;
      branch_off_q <= 11'h000;
      call_mode_q <= 1'b0;
      table_mode_q <= 2'h0;
      ext_word_q <= 12'h000;
    end else begin
      fetch_take_q <= fetch_take_d;
      cls_q <= cls_d;
      double_q <= double_d;
      pc_change_q <= pc_change_d;
      cond_q <= cond_d;
      is_nop_q <= is_nop_d;
      second_word_q <= second_word_d;
      file_addr_q <= file_addr_d;
      dest_file_q <= dest_file_d;
      access_sel_q <= access_sel_d;
      bit_num_q <= bit_num_d;
      literal_q <= literal_d;
      pointer_sel_q <= pointer_sel_d;
      branch_off_q <= branch_off_d;
      call_mode_q <= call_mode_d;
      table_mode_q <= table_mode_d;
      ext_word_q <= ext_word_d;
    end
  end

  assign instr_class_q = cls_q;

  // Cycle sequencing: decided at the end of the write phase
  always_comb begin
    taken = !is_nop_q && (pc_change_q || (cond_q && cond_true));
    state_d = state_q;
    cycle_end_d = (phase_q == CIFD_PH_WRITE);
    if (phase_q == CIFD_PH_WRITE) begin
      case (state_q)
        ST_EXEC: begin
          if (double_q && !is_nop_q) begin
            state_d = ST_SECOND;
          end else if (taken) begin
            state_d = ST_FLUSH;
          end else begin
            state_d = ST_EXEC;
          end
        end
        ST_SECOND: begin
          state_d = ST_EXEC;
        end
        ST_FLUSH: begin
          // A skipped two-word instruction costs its second word too
          state_d = double_q ? ST_FLUSH : ST_EXEC;
        end
        default: begin
          state_d = ST_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_EXEC;
      cycle_end_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cycle_end_q <= cycle_end_d;
    end
  end

  // Working register path: literal read in phase two, written in phase four
  always_comb begin
    lit_hold_d = lit_hold_q;
    working_register_d = working_register_q;
    if (phase_q == CIFD_PH_READ) begin
      lit_hold_d = literal_q;
    end
    // Process phase needs no work for a plain literal copy
    if (phase_q == CIFD_PH_WRITE && !is_nop_q) begin
      if (cls_q == CLS_LOAD_LIT) begin
        working_register_d = lit_hold_q;
      end else if (cls_q == CLS_BYTE && !double_q && !dest_file_q) begin
        working_register_d = alu_result;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lit_hold_q <= CIFD_WORKING_RST;
      working_register_q <= CIFD_WORKING_RST;
    end else begin
      lit_hold_q <= lit_hold_d;
      working_register_q <= working_register_d;
    end
  end

  a_fetch_take: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_DECODE) |=> fetch_take_q ##1 !fetch_take_q)
    else $error("fetch take not a pulse after decode phase");

  a_orphan_nop: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_DECODE && state_q == ST_EXEC && fetch_word[15:12] == 4'hf)
    |=> is_nop_q)
    else $error("lone second word not treated as no-op");

  a_dest_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_DECODE && state_q == ST_EXEC && f_cls == CLS_BYTE)
    |=> (dest_file_q == $past(fetch_word[9])) && (file_addr_q == $past(fetch_word[7:0])))
    else $error("byte operand fields wrong");

  a_bit_fields: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_DECODE && f_cls == CLS_BIT)
    |=> (bit_num_q == $past(fetch_word[11:9])) && (access_sel_q == $past(fetch_word[8])))
    else $error("bit operand fields wrong");

  a_double_two: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_WRITE && state_q == ST_EXEC && double_q && !is_nop_q)
    |=> (state_q == ST_SECOND) [*4] ##1 (state_q == ST_EXEC))
    else $error("double-word instruction not two cycles");

  a_taken_extra: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_WRITE && state_q == ST_EXEC && !double_q && taken)
    |=> (state_q == ST_FLUSH) ##1 is_nop_q)
    else $error("taken instruction lacks its no-op cycle");

  a_single_one: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_WRITE && state_q == ST_EXEC && !double_q && !taken)
    |=> (state_q == ST_EXEC))
    else $error("plain instruction took more than one cycle");

  a_skip_long: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_WRITE && state_q == ST_FLUSH && double_q)
    |=> (state_q == ST_FLUSH) [*4] ##1 (state_q == ST_EXEC))
    else $error("skipped two-word instruction not fully flushed");

  a_load_lit_wr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_DECODE && state_q == ST_EXEC && fetch_word[15:8] == 8'h0e)
    |=> ##2 $stable(working_register_q) ##1 (working_register_q == $past(fetch_word[7:0], 4)))
    else $error("load literal did not write working register in phase four");

  c_load_lit: cover property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == CIFD_PH_WRITE && cls_q == CLS_LOAD_LIT && !is_nop_q));
  c_double: cover property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_SECOND && phase_q == CIFD_PH_WRITE));
  c_flush: cover property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_FLUSH && double_q && phase_q == CIFD_PH_WRITE));

endmodule

// ---- cifd_fetch_model.sv ----
// Program memory fetch path model feeding one word per instruction cycle.
// Assumes the decoder samples fetch_word at the edge that ends phase 0.
`timescale 1ns/100ps
module cifd_fetch_model
  import cifd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] phase_q,
  input wire logic [15:0] prog [64],
  output logic [15:0] fetch_word
);
  logic [5:0] ptr_q; // Index of the next word to present

  // Present a word for phase 0 only; garble it once it has been taken
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q <= 6'h00;
      fetch_word <= prog[0];
    end else if (phase_q == CIFD_PH_WRITE) begin
      fetch_word <= prog[ptr_q];
    end else if (phase_q == CIFD_PH_DECODE) begin
      fetch_word <= ~fetch_word;
      ptr_q <= ptr_q + 6'h01;
    end
  end
endmodule

// ---- core_instruction_format_decode_tb.sv ----
// Self-checking bench for the instruction format decoder.
// Assumes the fetch model delivers prog[i] in instruction cycle i.
`timescale 1ns/100ps
module core_instruction_format_decode_tb;
  import cifd_pkg::*;
  `define CHK(nm, e, g) cmp(nm, 16'(e), 16'(g))

  logic sys_clk = 1'b0; // Clock
  logic reset_n; // Reset, active low
  logic cond_true = 1'b0; // Condition outcome
  logic [15:0] fetch_word; // Word from the fetch model
  logic [7:0] alu_result = 8'h00; // Byte result for byte ops
  logic [7:0] file_addr_q, literal_q, working_register_q;
  logic [1:0] phase_q, pointer_sel_q, table_mode_q;
  logic [2:0] instr_class_q, bit_num_q;
  logic [10:0] branch_off_q;
  logic [11:0] ext_word_q;
  logic fetch_take_q, is_nop_q, second_word_q, dest_file_q, access_sel_q;
  logic call_mode_q, cycle_end_q;
  logic [15:0] prog [64]; // Program image
  int miscompares, checks, cyc_cnt, cond_mode;

  cifd_decoder DUT (.sys_clk(sys_clk), .reset_n(reset_n), .fetch_word(fetch_word),
    .cond_true(cond_true), .alu_result(alu_result), .phase_q(phase_q),
    .fetch_take_q(fetch_take_q), .instr_class_q(instr_class_q), .is_nop_q(is_nop_q),
    .second_word_q(second_word_q), .file_addr_q(file_addr_q), .dest_file_q(dest_file_q),
    .access_sel_q(access_sel_q), .bit_num_q(bit_num_q), .literal_q(literal_q),
    .pointer_sel_q(pointer_sel_q), .branch_off_q(branch_off_q), .call_mode_q(call_mode_q),
    .table_mode_q(table_mode_q), .ext_word_q(ext_word_q),
    .working_register_q(working_register_q), .cycle_end_q(cycle_end_q));

  cifd_fetch_model fetch (.sys_clk(sys_clk), .reset_n(reset_n), .phase_q(phase_q),
    .prog(prog), .fetch_word(fetch_word));

  // Clock of 50 ns period
  always #25 sys_clk = ~sys_clk;

  // New condition and byte result each instruction cycle
  always @(posedge sys_clk) begin
    if (phase_q === 2'h0) begin
      cond_true <= (cond_mode == 0) ? 1'($urandom) : (cond_mode == 1);
      alu_result <= 8'($urandom);
    end
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // First half of a two-word instruction
  function automatic logic is_dbl(input logic [15:0] w);
    return w[15:12] == 4'hc || w[15:10] == 6'b111011;
  endfunction

  // Word that always redirects the program counter
  function automatic logic pc_chg(input logic [15:0] w);
    return w[15:12] == 4'hd || w[15:1] == 15'h0009;
  endfunction

  function automatic logic is_cond(input logic [15:0] w);
    return w[15:13] == 3'b101 || w[15:11] == 5'b11100;
  endfunction

  // Expected class, 7 where not checked
  function automatic logic [2:0] exp_cls(input logic [15:0] w);
    if (w == 16'h0000) return 3'd0;
    if (w[15:8] == 8'h0e) return 3'd5;
    if (w[15:12] inside {[4'h1:4'h5]}) return 3'd1;
    if (w[15:12] inside {[4'h6:4'h9]}) return 3'd2;
    if (w[15:12] == 4'hd) return 3'd4;
    if (w[15:10] == 6'b111010 || w[15:8] inside {[8'h01:8'h0d]}) return 3'd3;
    return 3'd7;
  endfunction

  // Random word of a chosen kind
  function automatic logic [15:0] gen_word(input int sel, input logic [15:0] r);
    case (sel)
      0: return {4'h1 + 4'(r[14:12] % 3'h5), r[11:0]};
      1: return {4'h6 + {2'b00, r[13:12]}, r[11:0]};
      2: return {8'h0e, r[7:0]};
      3: return {6'b111010, r[9:0]};
      4: return {3'b101, r[12:0]};
      5: return {4'hd, r[11:0]};
      6: return {5'b11100, r[10:0]};
      7: return r[12] ? {4'hc, r[11:0]} : {6'b111011, r[9:0]};
      default: return {4'hf, r[11:0]};
    endcase
  endfunction

  task automatic load(input logic [15:0] q[$]);
    for (int i = 0; i < 64; i++)
      prog[i] = (i < q.size()) ? q[i] : 16'h0000;
  endtask

  task automatic rand_prog();
    int i;
    logic [15:0] r;
    foreach (prog[j]) prog[j] = 16'h0000;
    i = 0;
    while (i < 60) begin
      r = 16'($urandom);
      prog[i] = gen_word($urandom % 9, r);
      if (is_dbl(prog[i])) begin
        i++;
        prog[i] = {4'hf, r[11:0] ^ 12'h5a5};
      end
      i++;
    end
  endtask

  // Reset, then check every instruction cycle against a reference walk
  task automatic run_prog(input int n);
    int st, gap;
    logic [15:0] w;
    logic [7:0] wexp;
    logic [2:0] c;
    st = 0;
    wexp = 8'h00;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < n; i++) begin
      gap = 0;
      do begin
        @(negedge sys_clk);
        gap++;
        if (phase_q === 2'h0 && i > 0) `CHK("cycle end", 1, cycle_end_q);
      end while (phase_q !== 2'h1 && gap < 8);
      if (i > 0) `CHK("clocks per cycle", 4, gap);
      w = prog[i];
      `CHK("working_register", wexp, working_register_q);
      `CHK("second", st == 1, second_word_q);
      if (st == 1) begin
        `CHK("ext word", w[11:0], ext_word_q);
        `CHK("class", 6, instr_class_q);
        st = 0;
      end else if (st == 2) begin
        `CHK("flush", 1, is_nop_q);
        `CHK("class", 0, instr_class_q);
        st = is_dbl(w) ? 2 : 0;
      end else begin
        c = exp_cls(w);
        `CHK("take", 1, fetch_take_q);
        `CHK("nop", w[15:12] == 4'hf || w == 16'h0000, is_nop_q);
        if (c != 3'd7) `CHK("class", c, instr_class_q);
        if (c == 3'd1 || c == 3'd2) `CHK("file", w[7:0], file_addr_q);
        if (c == 3'd1 || c == 3'd2) `CHK("access", w[8], access_sel_q);
        if (c == 3'd1) `CHK("dest", w[9], dest_file_q);
        if (c == 3'd2 || w[15:13] == 3'b101) `CHK("bit", w[11:9], bit_num_q);
        if (c == 3'd3 || c == 3'd5) `CHK("literal", w[7:0], literal_q);
        if (w[15:12] == 4'hd) `CHK("offset", w[10:0], branch_off_q);
        if (w[15:11] == 5'b11100) `CHK("offset", w[7:0], branch_off_q);
        if (w[15:9] == 7'b1110110) `CHK("call mode", w[8], call_mode_q);
        if (w[15:1] == 15'h0009) `CHK("call mode", w[0], call_mode_q);
        if (w[15:8] == 8'h00 && w[7:0] != 8'h00) `CHK("table mode", w[1:0], table_mode_q);
        if (w[15:8] == 8'hee) `CHK("pointer", w[5:4], pointer_sel_q);
        if (c == 3'd5) wexp = w[7:0];
        else if (c == 3'd1 && !w[9]) wexp = alu_result;
        if (is_dbl(w)) st = 1;
        else if (pc_chg(w) || (is_cond(w) && cond_true)) st = 2;
      end
    end
  endtask

  // Hand-made corner programs, then random ones
  initial begin
    void'($urandom(19019));
    reset_n = 1'b0;
    miscompares = 0;
    checks = 0;
    cyc_cnt = 0;
    cond_mode = 0;
    load('{16'h0e5a, 16'h1034, 16'h2a34, 16'hf123, 16'h0000, 16'h0912, 16'h0012,
      16'h0e00, 16'h0e33, 16'h000a});
    run_prog(10);
    cond_mode = 1;
    load('{16'ha201, 16'hef12, 16'hf345, 16'h0eff, 16'he005, 16'h0e11, 16'h0013,
      16'hc123, 16'hf456, 16'h0e77});
    run_prog(12);
    cond_mode = 2;
    load('{16'hec80, 16'hf001, 16'hed00, 16'hf002, 16'hee25, 16'hf003, 16'hc456,
      16'hf004, 16'ha000, 16'he0ff, 16'hb111, 16'hd7ff, 16'h0e01, 16'h0eaa});
    run_prog(16);
    cond_mode = 0;
    repeat (4) begin
      rand_prog();
      run_prog(62);
    end
    finish_test();
  end
endmodule
